//--- verilog/sls_pkg.sv
// Operation
// - Reference-to-boundary latency 4 cycles (3.5 rounded up) or 8 cycles.
// - Latency 15 or 29 for ratios four, eight.
// - First K28.5 frame 5..7 frames after boundary.
// - First alignment frame 5..7 frames after boundary.
// - First data frame 5..7 frames after boundary.
// - Alignment sequence lasts exactly 4 multi-frames.
// - Lane bit rate between 1.0 and 7.4 Gb/s.
// - Multi-frame clock derived, aligned to reference pulse.
package sls_pkg;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int SLS_CLK_MHZ = 100;
   // Latency for ratio one is 3.5 device cycles, kept in tenths.
   localparam int SLS_LAT_DIV1_X10 = 35;
   localparam int SLS_LAT_DIV1_CYC = (SLS_LAT_DIV1_X10 + 9) / 10;
   localparam int SLS_LAT_DIV2_CYC = 8;
   localparam int SLS_LAT_DIV4_CYC = 15;
   localparam int SLS_LAT_DIV8_CYC = 29;
   localparam int SLS_TX_DELAY_FRAMES = 6;
   localparam int SLS_TX_DELAY_MIN = 5;
   localparam int SLS_TX_DELAY_MAX = 7;
   localparam int SLS_ILA_MULTIFRAMES = 4;
   localparam int SLS_FRAMES_PER_MF = 16;
   localparam int SLS_FIFO_DEPTH = 16;
   localparam int SLS_LANE_RATE_MIN_MBPS = 1000;
   localparam int SLS_LANE_RATE_MAX_MBPS = 7400;
   localparam int SLS_LANE_RATE_MBPS = 7400;

   // ==========================================================
   // Characters and reset values
   // ==========================================================
   localparam logic [7:0] SLS_K28_5 = 8'hbc;
   localparam logic [7:0] SLS_K28_0 = 8'h1c;
   localparam logic [7:0] SLS_K28_3 = 8'h7c;
   localparam logic [2:0] SLS_PIN_N_RESET = 3'h7;

   typedef enum logic [1:0] {SLS_CGS, SLS_ILA, SLS_DATA} sls_phase_e;

   // ==========================================================
   // Decoding of the divide ratio code
   // ==========================================================
   function automatic logic [3:0] sls_ratio(input logic [1:0] code);
      unique case (code)
         2'h0: sls_ratio = 4'h1;
         2'h1: sls_ratio = 4'h2;
         2'h2: sls_ratio = 4'h4;
         2'h3: sls_ratio = 4'h8;
      endcase
   endfunction

   function automatic logic [4:0] sls_latency(input logic [1:0] code);
      unique case (code)
         2'h0: sls_latency = 5'(SLS_LAT_DIV1_CYC);
         2'h1: sls_latency = 5'(SLS_LAT_DIV2_CYC);
         2'h2: sls_latency = 5'(SLS_LAT_DIV4_CYC);
         2'h3: sls_latency = 5'(SLS_LAT_DIV8_CYC);
      endcase
   endfunction

endpackage

//--- verilog/sls_fifo.sv
`timescale 1ns/1ns
module sls_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic [AW:0] cnt_d;
   logic push;
   logic pop;

   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_data_o = mem_q[rd_q];

   always_comb begin
      cnt_d = cnt_q;
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         in_ready_o <= 1'b0;
         out_valid_o <= 1'b0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_d;
         in_ready_o <= (cnt_d != FULL);
         out_valid_o <= (cnt_d != '0);
      end
   end
endmodule

//--- verilog/sls_sync_timing.sv
`timescale 1ns/1ns
module sls_sync_timing import sls_pkg::*; #(
   parameter int FRAMES_PER_MF = SLS_FRAMES_PER_MF,
   parameter int FIFO_DEPTH = SLS_FIFO_DEPTH,
   parameter int LANE_RATE_MBPS = SLS_LANE_RATE_MBPS
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [1:0] sampling_clock_divide_ratio_i,
   input wire logic reference_pulse_i,
   input wire logic link_sync_request_n_i,
   input wire logic sample_valid_i,
   input wire logic [7:0] sample_data_i,
   output logic sample_ready_o,
   output logic [7:0] lane_data_o,
   output logic lane_k_o,
   output logic lane_valid_o,
   output logic lmfc_o
);
   localparam int FW = $clog2(FRAMES_PER_MF);
   localparam int PIPE = SLS_TX_DELAY_FRAMES - 1;
   localparam logic [FW-1:0] LAST_FRAME = FW'(FRAMES_PER_MF - 1);
   localparam logic [2:0] ILA_LAST = 3'(SLS_ILA_MULTIFRAMES - 1);

   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   logic [2:0] sref_sync_q;
   logic [2:0] req_sync_q;
   logic sref_lvl_q;
   logic req_act_q;
   logic sref_rise;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sref_sync_q <= 3'h0;
         sref_lvl_q <= 1'b0;
      end else begin
         sref_sync_q <= {sref_sync_q[1:0], reference_pulse_i};
         if (sref_sync_q[2] == sref_sync_q[1]) begin
            sref_lvl_q <= sref_sync_q[2];
         end
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         req_sync_q <= SLS_PIN_N_RESET;
         req_act_q <= 1'b0;
      end else begin
         req_sync_q <= {req_sync_q[1:0], link_sync_request_n_i};
         if (req_sync_q[2] == req_sync_q[1]) begin
            req_act_q <= !req_sync_q[2];
         end
      end
   end

   assign sref_rise = sref_sync_q[2] && sref_sync_q[1] && !sref_lvl_q;

   // ==========================================================
   // Frame and multi-frame clock generation
   // ==========================================================
   logic [3:0] ratio;
   logic [4:0] lat_cnt_q;
   logic align;
   logic [2:0] div_q;
   logic [FW-1:0] frame_q;
   logic frame_en_q;
   logic lmfc_q;

   assign ratio = sls_ratio(sampling_clock_divide_ratio_i);
   assign align = (lat_cnt_q == 5'h1);

   // The boundary is forced a fixed latency after the latched edge.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         lat_cnt_q <= 5'h0;
      end else if (sref_rise) begin
         lat_cnt_q <= sls_latency(sampling_clock_divide_ratio_i) - 5'h1;
      end else if (lat_cnt_q != 5'h0) begin
         lat_cnt_q <= lat_cnt_q - 5'h1;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         div_q <= 3'h0;
         frame_q <= '0;
         frame_en_q <= 1'b0;
         lmfc_q <= 1'b0;
      end else if (align) begin
         div_q <= 3'h0;
         frame_q <= '0;
         frame_en_q <= 1'b1;
         lmfc_q <= 1'b1;
      end else if ({1'b0, div_q} >= ratio - 4'h1) begin
         div_q <= 3'h0;
         frame_en_q <= 1'b1;
         frame_q <= (frame_q == LAST_FRAME) ? '0 : frame_q + 1'b1;
         lmfc_q <= (frame_q == LAST_FRAME);
      end else begin
         div_q <= div_q + 3'h1;
         frame_en_q <= 1'b0;
         lmfc_q <= 1'b0;
      end
   end

   // ==========================================================
   // Link phase sequencing
   // ==========================================================
   sls_phase_e phase_q;
   logic rel_q;
   logic resync_q;
   logic [2:0] ila_cnt_q;

   // A request shorter than a multi-frame is remembered for the boundary, except when it comes in SLS_CGS.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         resync_q <= 1'b0;
      end else if (req_act_q && phase_q != SLS_CGS) begin
         resync_q <= 1'b1;
      end else if (lmfc_q) begin
         resync_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         phase_q <= SLS_CGS;
         rel_q <= 1'b0;
         ila_cnt_q <= 3'h0;
      end else if (lmfc_q) begin
         if (req_act_q || resync_q) begin
            phase_q <= SLS_CGS;
            rel_q <= 1'b0;
         end else begin
            unique case (phase_q)
               SLS_CGS: begin
                  if (rel_q) begin
                     phase_q <= SLS_ILA;
                     ila_cnt_q <= 3'h0;
                  end else begin
                     rel_q <= 1'b1;
                  end
               end
               SLS_ILA: begin
                  if (ila_cnt_q == ILA_LAST) begin
                     phase_q <= SLS_DATA;
                  end else begin
                     ila_cnt_q <= ila_cnt_q + 3'h1;
                  end
               end
               SLS_DATA: begin
                  phase_q <= SLS_DATA;
               end
            endcase
         end
      end
   end

   // ==========================================================
   // Transmit pipeline and character selection
   // ==========================================================
   sls_phase_e ph_pipe_q [PIPE];
   logic [FW-1:0] fr_pipe_q [PIPE];
   sls_phase_e out_phase_q;
   logic fifo_valid;
   logic fifo_pop;
   logic [7:0] fifo_data;
   logic [FW-1:0] prev_fr_q;

   assign fifo_pop = frame_en_q && ph_pipe_q[PIPE-1] == SLS_DATA;

   // The phase settles one cycle after a boundary pulse, so each phase
   // is paired with the index of the frame pulse before it.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         prev_fr_q <= '0;
      end else if (frame_en_q) begin
         prev_fr_q <= frame_q;
      end
   end

   // Each phase reaches the lane a fixed number of frames late.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         for (int i = 0; i < PIPE; i++) begin
            ph_pipe_q[i] <= SLS_CGS;
            fr_pipe_q[i] <= '0;
         end
      end else if (frame_en_q) begin
         ph_pipe_q[0] <= phase_q;
         fr_pipe_q[0] <= prev_fr_q;
         for (int i = 1; i < PIPE; i++) begin
            ph_pipe_q[i] <= ph_pipe_q[i-1];
            fr_pipe_q[i] <= fr_pipe_q[i-1];
         end
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         out_phase_q <= SLS_CGS;
         lane_data_o <= SLS_K28_5;
         lane_k_o <= 1'b1;
         lane_valid_o <= 1'b0;
         lmfc_o <= 1'b0;
      end else begin
         lane_valid_o <= frame_en_q;
         lmfc_o <= lmfc_q;
         if (frame_en_q) begin
            out_phase_q <= ph_pipe_q[PIPE-1];
            unique case (ph_pipe_q[PIPE-1])
               SLS_CGS: begin
                  lane_data_o <= SLS_K28_5;
                  lane_k_o <= 1'b1;
               end
               SLS_ILA: begin
                  if (fr_pipe_q[PIPE-1] == '0) begin
                     lane_data_o <= SLS_K28_0;
                     lane_k_o <= 1'b1;
                  end else if (fr_pipe_q[PIPE-1] == LAST_FRAME) begin
                     lane_data_o <= SLS_K28_3;
                     lane_k_o <= 1'b1;
                  end else begin
                     lane_data_o <= 8'(fr_pipe_q[PIPE-1]);
                     lane_k_o <= 1'b0;
                  end
               end
               SLS_DATA: begin
                  lane_data_o <= fifo_valid ? fifo_data : 8'h00;
                  lane_k_o <= 1'b0;
               end
            endcase
         end
      end
   end

   sls_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .in_valid_i(sample_valid_i),
      .in_data_i(sample_data_i),
      .in_ready_o(sample_ready_o),
      .out_valid_o(fifo_valid),
      .out_data_o(fifo_data),
      .out_ready_i(fifo_pop)
   );

   // ==========================================================
   // Checks
   // ==========================================================
   localparam int LAT1 = SLS_LAT_DIV1_CYC;
   localparam int LAT2 = SLS_LAT_DIV2_CYC;
   localparam int LAT4 = SLS_LAT_DIV4_CYC;
   localparam int LAT8 = SLS_LAT_DIV8_CYC;
   logic [3:0] fsl_q;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         fsl_q <= 4'hf;
      end else if (lmfc_q) begin
         fsl_q <= 4'h0;
      end else if (frame_en_q && fsl_q != 4'hf) begin
         fsl_q <= fsl_q + 4'h1;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   sequence s_release_seen;
      lmfc_q && !req_act_q && !resync_q && phase_q == SLS_CGS && rel_q;
   endsequence

   sequence s_ila_entered;
      ##1 phase_q == SLS_ILA && ila_cnt_q == 3'h0;
   endsequence

   a_lat_div_one: assert property (sref_rise && sampling_clock_divide_ratio_i == 2'h0 |-> ##LAT1 lmfc_q) else $error("latency ratio one wrong");
   a_lat_div_two: assert property (sref_rise && sampling_clock_divide_ratio_i == 2'h1 |-> ##LAT2 lmfc_q) else $error("latency ratio two wrong");
   a_lat_div_four: assert property (sref_rise && sampling_clock_divide_ratio_i == 2'h2 |-> ##LAT4 lmfc_q) else $error("latency ratio four wrong");
   a_lat_div_eight: assert property (sref_rise && sampling_clock_divide_ratio_i == 2'h3 |-> ##LAT8 lmfc_q) else $error("latency ratio eight wrong");
   a_cgs_start_delay: assert property ($changed(out_phase_q) && out_phase_q == SLS_CGS |-> fsl_q >= 4'h5 && fsl_q <= 4'h7) else $error("K28.5 start off");
   a_ila_start_delay: assert property ($changed(out_phase_q) && out_phase_q == SLS_ILA |-> fsl_q >= 4'h5 && fsl_q <= 4'h7) else $error("alignment start off");
   a_data_start_delay: assert property ($changed(out_phase_q) && out_phase_q == SLS_DATA |-> fsl_q >= 4'h5 && fsl_q <= 4'h7) else $error("data start off");
   a_ila_mf_length: assert property ($rose(phase_q == SLS_DATA) |-> $past(phase_q) == SLS_ILA && $past(ila_cnt_q) == ILA_LAST) else $error("alignment length wrong");
   a_lane_rate_range: assert property (LANE_RATE_MBPS >= SLS_LANE_RATE_MIN_MBPS && LANE_RATE_MBPS <= SLS_LANE_RATE_MAX_MBPS) else $error("lane rate out of range");
   a_lmfc_on_frame: assert property (lmfc_q |-> frame_en_q && frame_q == '0) else $error("boundary off frame");
   a_ila_after_release: assert property (s_release_seen |-> s_ila_entered) else $error("alignment not started");
   a_cgs_on_request: assert property (lmfc_q && req_act_q |=> phase_q == SLS_CGS && !rel_q ##1 lane_k_o || phase_q == SLS_CGS) else $error("request not honoured");
endmodule

//--- dv/sls_rx_model.sv
`timescale 1ns/1ns
module sls_rx_model import sls_pkg::*; (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic want_sync_i,
   input wire logic lmfc_i,
   input wire logic lane_valid_i,
   input wire logic [7:0] lane_data_i,
   input wire logic lane_k_i,
   output logic link_sync_request_n_o
);
   logic [2:0] kseen_q;

   // ==========================================================
   // Code-group lock
   // ==========================================================
   // Counts consecutive K28.5 frames; four of them count as lock.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         kseen_q <= 3'h0;
      end else if (lane_valid_i) begin
         if (lane_k_i && lane_data_i == SLS_K28_5) begin
            if (kseen_q != 3'h4) begin
               kseen_q <= kseen_q + 3'h1;
            end
         end else begin
            kseen_q <= 3'h0;
         end
      end
   end

   // ==========================================================
   // Request
   // ==========================================================
   // Changing only just after a boundary keeps the request settled a
   // whole multi-frame ahead of the next one and held for at least one.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         link_sync_request_n_o <= 1'b0;
      end else if (lmfc_i) begin
         link_sync_request_n_o <= !want_sync_i &&
            (link_sync_request_n_o || kseen_q == 3'h4);
      end
   end
endmodule

//--- dv/sls_sync_timing_tb.sv
`timescale 1ns/1ns
module sls_sync_timing_tb import sls_pkg::*; ;
   localparam int MF = 16;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [1:0] ratio = 2'h0;
   logic ref_pulse = 1'b0;
   logic want_sync = 1'b1;
   logic sample_valid = 1'b0;
   logic [7:0] sample_data = 8'h00;
   logic sample_ready;
   logic [7:0] lane_data;
   logic lane_k;
   logic lane_valid;
   logic lmfc;
   logic sync_req_n;
   int bad_count = 0;
   int check_count = 0;

   always #5 clk_i = ~clk_i;

   sls_sync_timing #(.FRAMES_PER_MF(MF), .FIFO_DEPTH(16),
      .LANE_RATE_MBPS(SLS_LANE_RATE_MBPS)) DUT (
      .clk_i(clk_i), .resetn_i(resetn_i),
      .sampling_clock_divide_ratio_i(ratio),
      .reference_pulse_i(ref_pulse),
      .link_sync_request_n_i(sync_req_n),
      .sample_valid_i(sample_valid), .sample_data_i(sample_data),
      .sample_ready_o(sample_ready), .lane_data_o(lane_data),
      .lane_k_o(lane_k), .lane_valid_o(lane_valid), .lmfc_o(lmfc));

   sls_rx_model rx (
      .clk_i(clk_i), .resetn_i(resetn_i), .want_sync_i(want_sync),
      .lmfc_i(lmfc), .lane_valid_i(lane_valid), .lane_data_i(lane_data),
      .lane_k_i(lane_k), .link_sync_request_n_o(sync_req_n));

   // ==========================================================
   // Helpers
   // ==========================================================
   task automatic step();
      @(posedge clk_i);
      #1;
   endtask

   task automatic check_eq(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_in(input int got, input int lo, input int hi);
      check_count++;
      if (got < lo || got > hi) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h..%h", $time,
            got, lo, hi);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Clock cycles since the last boundary pulse when the wanted octet shows.
   task automatic wait_lane(input logic [7:0] d, input logic k,
      output int n);
      int i;
      n = 0;
      for (i = 0; i < 200; i++) begin
         step();
         if (lmfc === 1'b1) n = 0;
         else n++;
         if (lane_valid === 1'b1 && lane_data === d && lane_k === k) break;
      end
      if (i == 200) n = -1;
   endtask

   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic t_latency(input logic [1:0] code);
      int n;
      int r;
      int lat;
      int per;
      int ones;
      r = 1 << code;
      lat = (code == 2'h0) ? SLS_LAT_DIV1_CYC : (code == 2'h1) ?
         SLS_LAT_DIV2_CYC : (code == 2'h2) ? SLS_LAT_DIV4_CYC :
         SLS_LAT_DIV8_CYC;
      per = MF * r;
      ones = 0;
      ratio = code;
      repeat (40) step();
      ref_pulse = 1'b1;
      for (n = 1; n <= 4 + lat + per; n++) begin
         step();
         if (n == 2 * r + 2) ref_pulse = 1'b0;
         if (n == 4 + lat) check_eq({7'h0, lmfc}, 8'h01);
         else if (n < 4 + lat + per && n > 4 + lat && lmfc !== 1'b0) ones++;
      end
      check_eq({7'h0, lmfc}, 8'h01);
      check_in(ones, 0, 0);
      $display("test latency code %0d done", code);
   endtask

   task automatic t_fill();
      int cnt;
      int i;
      cnt = 0;
      for (i = 0; i < 20 && sample_ready === 1'b1; i++) begin
         sample_data = 8'ha0 + 8'(cnt);
         sample_valid = 1'b1;
         step();
         cnt++;
      end
      sample_valid = 1'b0;
      check_in(cnt, 16, 16);
      repeat (20) step();
      check_eq({7'h0, sample_ready}, 8'h00);
      check_eq(lane_data, SLS_K28_5);
      check_eq({7'h0, lane_k}, 8'h01);
      $display("test fill done");
   endtask

   task automatic t_ila();
      int n;
      int f;
      want_sync = 1'b0;
      wait_lane(SLS_K28_0, 1'b1, n);
      check_in(n, 5, 7);
      for (f = 1; f <= 80; f++) begin
         step();
         if (lmfc === 1'b1) n = 0;
         else n++;
         if (f == 1) check_eq(lane_data, 8'h01);
         if (f == MF) check_eq(lane_data, SLS_K28_0);
         if (f == 4 * MF - 1) check_eq(lane_data, SLS_K28_3);
         if (f == 4 * MF) check_in(n, 5, 7);
         if (f >= 4 * MF && f < 80) begin
            check_eq(lane_data, 8'ha0 + 8'(f - 4 * MF));
            check_eq({7'h0, lane_k}, 8'h00);
         end
         if (f == 80) check_eq(lane_data, 8'h00);
      end
      check_eq({7'h0, sample_ready}, 8'h01);
      $display("test alignment and data done");
   endtask

   task automatic t_resync();
      int n;
      want_sync = 1'b1;
      wait_lane(SLS_K28_5, 1'b1, n);
      check_in(n, 5, 7);
      $display("test resync done");
   endtask

   // ==========================================================
   // Sequence
   // ==========================================================
   initial begin
      int c;
      repeat (2) @(posedge clk_i);
      #1;
      check_eq(lane_data, SLS_K28_5);
      check_eq({4'h0, lane_k, lane_valid, lmfc, sample_ready}, 8'h08);
      repeat (10) @(posedge clk_i);
      #1;
      resetn_i = 1'b1;
      for (c = 3; c >= 0; c--) t_latency(2'(c));
      t_fill();
      t_ila();
      t_resync();
      tally_and_finish();
   end

   initial begin
      #50000;
      bad_count++;
      $display("unexpected at %0t: timeout %h %h", $time, check_count, 0);
      tally_and_finish();
   end
endmodule
